// ===== hw/cfg_loader_pkg.sv
package cfg_loader_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_IMG = 8'h08;
  localparam logic [7:0] REG_PBASE = 8'h0C;
  localparam logic [7:0] REG_RBA = 8'h10;
  localparam logic [7:0] REG_RBD = 8'h14;
  localparam logic [7:0] REG_ISTAT = 8'h18;
  localparam logic [7:0] REG_IEN = 8'h1C;
  localparam logic [7:0] REG_ICLR = 8'h20;
  localparam logic [7:0] REG_DIV = 8'h24;

  // control bits and interrupt bits
  localparam int CTRL_REBOOT = 0;
  localparam int CTRL_PART = 1;
  localparam int CTRL_EXTCLK = 2;
  localparam int CTRL_FUSEKEY = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_FALLBACK = 2;
  localparam int IRQ_PROG = 3;
  localparam int IRQ_W = 4;

  // image format and reset values
  localparam logic [31:0] SYNC_WORD = 32'hA5C35AC3;
  localparam logic [31:0] LFSR_POLY = 32'h04C11DB7;
  localparam int HDR_ENC_BIT = 31;
  localparam logic [7:0] DIV_RST = 8'h04;
  localparam logic [15:0] SYNC_LIMIT = 16'h0100;
  localparam logic [15:0] SETTLE_CYC = 16'h0003;

  typedef enum logic [2:0] {
    MD_SER_FLASH = 3'b000,
    MD_PAR_FLASH = 3'b001,
    MD_SLV8 = 3'b010,
    MD_SLV16 = 3'b011,
    MD_SLV32 = 3'b100
  } mode_t;

  typedef enum logic [2:0] {
    W1 = 3'b000, W2 = 3'b001, W4 = 3'b010, W8 = 3'b011, W16 = 3'b100, W32 = 3'b101
  } width_t;

  typedef enum logic [3:0] {
    ST_HOLD = 4'b0000, ST_CLEAR = 4'b0001, ST_DETECT = 4'b0010, ST_SYNC = 4'b0011,
    ST_HEAD = 4'b0100, ST_DATA = 4'b0101, ST_CHECK = 4'b0110, ST_DONE = 4'b0111,
    ST_FAIL = 4'b1000
  } st_t;

  typedef struct packed {
    logic en;
    logic we;
    logic [6:0] addr;
    logic [15:0] wdata;
  } dcp_req_t;

  typedef struct packed {
    logic rdy;
    logic [15:0] rdata;
  } dcp_rsp_t;

  typedef struct packed {
    logic clk;
    logic cs_n;
    logic [23:0] addr;
  } flash_out_t;

endpackage : cfg_loader_pkg

// ===== hw/cfg_loader.sv
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module cfg_loader
  import cfg_loader_pkg::*;
#(
  parameter int CFG_WORDS = 1024,
  parameter int DCP_DEPTH = 128,
  parameter longint IMG_MIN_BITS = 10000000,
  parameter longint IMG_MAX_BITS = 31000000
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_nrst, // sync reset, low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [7:0] i_paddr, // apb address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error
  input wire logic i_prog_n, // reload request pin, low
  input wire logic [2:0] i_mode, // mode select pins
  input wire logic i_ext_cfgclk, // external config clock
  input wire logic [15:0] i_flash_data, // flash data lanes
  output flash_out_t o_flash, // flash clock, select, address
  input wire logic i_slv_valid, // slave word strobe
  input wire logic [31:0] i_slv_data, // slave data
  input wire logic [255:0] i_bbram_key, // battery-backed key
  input wire logic [255:0] i_fuse_key, // fuse key store
  input wire dcp_req_t i_dcp, // dynamic config port request
  output dcp_rsp_t o_dcp, // dynamic config port answer
  output logic o_user_en, // user logic released
  output logic o_done, // load complete
  output logic o_error, // load failed
  output logic o_irq // interrupt level
);

  localparam int AW = $clog2(CFG_WORDS);
  localparam int DW = $clog2(DCP_DEPTH);
  localparam int SW = 54;

  if (CFG_WORDS < 2 || DCP_DEPTH < 2 || DCP_DEPTH > 128 || IMG_MIN_BITS > IMG_MAX_BITS)
  begin : g_chk
    $error("cfg_loader: bad parameters");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [5:0] wbits(input logic [2:0] wc);
    case (wc)
      W1: wbits = 6'd1;
      W2: wbits = 6'd2;
      W4: wbits = 6'd4;
      W8: wbits = 6'd8;
      W16: wbits = 6'd16;
      default: wbits = 6'd32;
    endcase
  endfunction : wbits

  function automatic logic [31:0] shift_in(input logic [31:0] a, input logic [31:0] d,
                                           input logic [2:0] wc);
    case (wc)
      W1: shift_in = {a[30:0], d[0]};
      W2: shift_in = {a[29:0], d[1:0]};
      W4: shift_in = {a[27:0], d[3:0]};
      W8: shift_in = {a[23:0], d[7:0]};
      W16: shift_in = {a[15:0], d[15:0]};
      default: shift_in = d;
    endcase
  endfunction : shift_in

  function automatic logic [31:0] lfsr(input logic [31:0] l);
    lfsr = {l[30:0], 1'b0} ^ (l[31] ? LFSR_POLY : 32'h00000000);
  endfunction : lfsr

  function automatic logic [31:0] fold(input logic [255:0] k);
    logic [31:0] f;
    f = 32'h00000000;
    for (int i = 0; i < 8; i++) begin
      f = f ^ k[i*32 +: 32];
    end
    fold = (f == 32'h00000000) ? 32'h00000001 : f;
  endfunction : fold

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [SW-1:0] meta_q, sync_q;
  logic prog_s, ext_s, sv_s;
  logic [2:0] mode_s;
  logic [15:0] fd_s;
  logic [31:0] sd_s;

  // every mode, program, clock, flash and slave pin goes through two flops; only sync_q is read
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {i_slv_data, i_slv_valid, i_flash_data, i_ext_cfgclk, i_mode, i_prog_n};
      sync_q <= meta_q;
    end
  end

  assign prog_s = sync_q[0];
  assign mode_s = sync_q[3:1];
  assign ext_s = sync_q[4];
  assign fd_s = sync_q[20:5];
  assign sv_s = sync_q[21];
  assign sd_s = sync_q[53:22];

  // ---------------------------------------------------------------
  // registers and loader state
  // ---------------------------------------------------------------
  st_t st_q;
  logic [2:0] mode_q, wc_q;
  logic part_q, alt_q, fb_q, enc_q, user_en_q, done_q, err_q;
  logic [29:0] len_q, idx_q;
  logic [31:0] csum_q, ks_q, acc_q, word_q;
  logic [5:0] bits_q;
  logic word_v_q;
  logic [15:0] to_q;
  logic [AW-1:0] clr_q;
  logic [23:0] base_q, img_q;
  logic [15:0] pbase_q, rba_q;
  logic ext_sel_q, fuse_sel_q;
  logic [7:0] div_reg_q, div_q;
  logic cfg_clk_q, ext_prev_q, sv_prev_q, prog_prev_q;
  logic [IRQ_W-1:0] ist_q, ien_q, ev;
  logic [31:0] rdata_d;
  logic hit_d;
  logic [31:0] mem [CFG_WORDS];
  logic [15:0] dcp_mem [DCP_DEPTH];

  logic wr, master, active, tick, rise, take, fail_now, size_bad, clr_last, sel;
  logic reboot_p, part_p;
  logic [31:0] plain, nxt;
  logic [29:0] midx;
  logic [34:0] img_bits;

  assign wr = i_psel && i_penable && i_pwrite && o_pready;
  assign reboot_p = wr && (i_paddr == REG_CTRL) && i_pwdata[CTRL_REBOOT];
  assign part_p = wr && (i_paddr == REG_CTRL) && i_pwdata[CTRL_PART];
  assign master = (mode_q == MD_SER_FLASH) || (mode_q == MD_PAR_FLASH);
  // lanes arrive two cycles late: hold the clock until selected data has come through
  assign sel = master && (st_q inside {ST_DETECT, ST_SYNC, ST_HEAD, ST_DATA, ST_CHECK});
  assign active = sel && !(st_q == ST_DETECT && to_q < SETTLE_CYC);

  // ---------------------------------------------------------------
  // config clock and sampling
  // ---------------------------------------------------------------
  // external source: each edge of the synced clock is a tick
  assign tick = ext_sel_q ? (ext_s != ext_prev_q) : (div_q == 8'h00);
  assign rise = active && tick && !cfg_clk_q;
  assign take = master ? (rise && st_q != ST_DETECT) : (sv_s && !sv_prev_q);
  assign nxt = shift_in(acc_q, master ? {16'h0000, fd_s} : sd_s, wc_q);

  // divider reloads from software; small values risk sampling stale data
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      div_q <= DIV_RST;
      cfg_clk_q <= 1'b0;
      ext_prev_q <= 1'b0;
      sv_prev_q <= 1'b0;
      prog_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_s;
      sv_prev_q <= sv_s;
      prog_prev_q <= prog_s;
      div_q <= (div_q == 8'h00) ? div_reg_q : div_q - 8'h01;
      cfg_clk_q <= active ? (cfg_clk_q ^ tick) : 1'b0;
    end
  end

  // flash address walks one step per sample
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_flash <= '{clk: 1'b0, cs_n: 1'b1, addr: 24'h000000};
    end else begin
      o_flash.clk <= active ? (cfg_clk_q ^ tick) : 1'b0;
      o_flash.cs_n <= !sel;
      if (st_q == ST_CLEAR) begin
        o_flash.addr <= base_q;
      end else if (rise) begin
        o_flash.addr <= o_flash.addr + 24'h000001;
      end
    end
  end

  // word assembly; width found from the first sample in flash modes
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      wc_q <= W1;
      acc_q <= '0;
      bits_q <= '0;
      word_q <= '0;
      word_v_q <= 1'b0;
    end else begin
      word_v_q <= 1'b0;
      if (st_q == ST_CLEAR) begin
        acc_q <= '0;
        bits_q <= '0;
        case (mode_q)
          MD_SLV8: wc_q <= W8;
          MD_SLV16: wc_q <= W16;
          default: wc_q <= W32;
        endcase
      end else if (st_q == ST_DETECT && rise) begin
        if (mode_q == MD_PAR_FLASH) begin
          wc_q <= (fd_s[15:8] == 8'hFF) ? W16 : W8;
        end else begin
          wc_q <= (fd_s[3:0] == 4'hF) ? W4 : (fd_s[1:0] == 2'h3) ? W2 : W1;
        end
      end else if (take) begin
        if (bits_q + wbits(wc_q) >= 6'd32) begin
          word_q <= nxt;
          word_v_q <= 1'b1;
          bits_q <= '0;
        end else begin
          bits_q <= bits_q + wbits(wc_q);
        end
        acc_q <= nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // loader sequence
  // ---------------------------------------------------------------
  assign plain = enc_q ? (word_q ^ ks_q) : word_q;
  assign img_bits = {word_q[29:0], 5'b00000};
  assign size_bad = (longint'(img_bits) < IMG_MIN_BITS)
                 || (longint'(img_bits) > IMG_MAX_BITS);
  assign clr_last = (clr_q == AW'(CFG_WORDS - 1));
  assign midx = (part_q ? {14'h0000, pbase_q} : 30'h00000000) + idx_q;
  assign fail_now = word_v_q && (((st_q == ST_SYNC) && word_q != SYNC_WORD && to_q == SYNC_LIMIT)
                 || ((st_q == ST_HEAD) && size_bad)
                 || ((st_q == ST_CHECK) && word_q != csum_q))
                 || ((st_q == ST_CLEAR) && clr_last && mode_q > MD_SLV32);

  // program pin beats everything; reboot beats normal flow
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st_q <= ST_HOLD;
      {part_q, alt_q, fb_q, enc_q, user_en_q, done_q, err_q} <= '0;
      {len_q, idx_q, csum_q, ks_q, to_q, clr_q, base_q} <= '0;
      mode_q <= MD_SER_FLASH;
      ev <= '0;
    end else begin
      ev <= '0;
      ev[IRQ_PROG] <= prog_prev_q && !prog_s;
      if (!prog_s) begin
        st_q <= ST_HOLD;
        user_en_q <= 1'b0;
        done_q <= 1'b0;
      end else if (reboot_p) begin
        st_q <= ST_CLEAR;
        {part_q, fb_q, user_en_q, done_q, err_q, clr_q} <= '0;
        alt_q <= 1'b1;
        base_q <= img_q;
        mode_q <= mode_s;
      end else if (fail_now) begin
        ev[IRQ_ERR] <= 1'b1;
        if (alt_q && !fb_q) begin
          st_q <= ST_CLEAR;
          {alt_q, base_q, clr_q} <= '0;
          fb_q <= 1'b1;
          ev[IRQ_FALLBACK] <= 1'b1;
        end else begin
          st_q <= part_q ? ST_DONE : ST_FAIL;
          err_q <= 1'b1;
        end
      end else begin
        case (st_q)
          ST_HOLD: begin
            st_q <= ST_CLEAR;
            {part_q, alt_q, fb_q, err_q, clr_q, base_q} <= '0;
            mode_q <= mode_s;
          end
          ST_CLEAR: begin
            clr_q <= clr_q + AW'(1);
            to_q <= '0;
            if (part_q || clr_last) begin
              st_q <= master ? ST_DETECT : ST_SYNC;
            end
          end
          ST_DETECT: begin
            if (rise) begin
              st_q <= ST_SYNC;
              to_q <= '0;
            end else if (to_q < SETTLE_CYC) begin
              to_q <= to_q + 16'h0001;
            end
          end
          ST_SYNC: begin
            if (word_v_q) begin
              to_q <= to_q + 16'h0001;
              if (word_q == SYNC_WORD) begin
                st_q <= ST_HEAD;
                csum_q <= '0;
                ks_q <= fold(fuse_sel_q ? i_fuse_key : i_bbram_key);
              end
            end
          end
          ST_HEAD: begin
            if (word_v_q) begin
              len_q <= word_q[29:0];
              enc_q <= word_q[HDR_ENC_BIT];
              idx_q <= '0;
              st_q <= (word_q[29:0] == 30'h00000000) ? ST_CHECK : ST_DATA;
            end
          end
          ST_DATA: begin
            if (word_v_q) begin
              csum_q <= {csum_q[30:0], csum_q[31]} ^ plain;
              ks_q <= lfsr(ks_q);
              idx_q <= idx_q + 30'h00000001;
              if (idx_q == len_q - 30'h00000001) begin
                st_q <= ST_CHECK;
              end
            end
          end
          ST_CHECK: begin
            if (word_v_q) begin
              st_q <= ST_DONE;
              user_en_q <= 1'b1;
              done_q <= 1'b1;
              ev[IRQ_DONE] <= 1'b1;
            end
          end
          ST_DONE: begin
            if (part_p && user_en_q) begin
              st_q <= ST_CLEAR;
              part_q <= 1'b1;
              base_q <= img_q;
              mode_q <= mode_s;
              err_q <= 1'b0;
            end
          end
          default: st_q <= ST_FAIL;
        endcase
      end
    end
  end

  // configuration memory; no reset, cleared by the sequence instead
  always_ff @(posedge i_clk_sys) begin
    if (st_q == ST_CLEAR && !part_q) begin
      mem[clr_q] <= '0;
    end else if (st_q == ST_DATA && word_v_q && midx < 30'(CFG_WORDS)) begin
      mem[AW'(midx)] <= plain;
    end
  end

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // read mux; readback reads live memory without touching user state
  always_comb begin
    rdata_d = 32'h00000000;
    hit_d = 1'b1;
    if (i_paddr == REG_CTRL) begin
      rdata_d = {28'h0000000, fuse_sel_q, ext_sel_q, 2'b00};
    end else if (i_paddr == REG_STAT) begin
      rdata_d = {16'h0000, part_q, alt_q, mode_q, wc_q, fb_q, err_q, done_q, user_en_q, st_q};
    end else if (i_paddr == REG_IMG) begin
      rdata_d = {8'h00, img_q};
    end else if (i_paddr == REG_PBASE) begin
      rdata_d = {16'h0000, pbase_q};
    end else if (i_paddr == REG_RBA) begin
      rdata_d = {16'h0000, rba_q};
    end else if (i_paddr == REG_RBD) begin
      rdata_d = (rba_q < 16'(CFG_WORDS)) ? mem[AW'(rba_q)] : 32'h00000000;
    end else if (i_paddr == REG_ISTAT) begin
      rdata_d = {28'h0000000, ist_q};
    end else if (i_paddr == REG_IEN) begin
      rdata_d = {28'h0000000, ien_q};
    end else if (i_paddr == REG_ICLR) begin
      rdata_d = 32'h00000000;
    end else if (i_paddr == REG_DIV) begin
      rdata_d = {24'h000000, div_reg_q};
    end else begin
      hit_d = 1'b0;
    end
  end

  // one wait-free access: ready rises in the access phase
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable && !o_pready;
      if (i_psel && !i_penable) begin
        o_prdata <= i_pwrite ? 32'h00000000 : rdata_d;
        o_pslverr <= !hit_d;
      end
    end
  end

  // software-written settings
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      {ext_sel_q, fuse_sel_q, img_q, pbase_q, rba_q, ien_q} <= '0;
      div_reg_q <= DIV_RST;
    end else if (wr) begin
      if (i_paddr == REG_CTRL) begin
        ext_sel_q <= i_pwdata[CTRL_EXTCLK];
        fuse_sel_q <= i_pwdata[CTRL_FUSEKEY];
      end else if (i_paddr == REG_IMG) begin
        img_q <= i_pwdata[23:0];
      end else if (i_paddr == REG_PBASE) begin
        pbase_q <= i_pwdata[15:0];
      end else if (i_paddr == REG_RBA) begin
        rba_q <= i_pwdata[15:0];
      end else if (i_paddr == REG_IEN) begin
        ien_q <= i_pwdata[IRQ_W-1:0];
      end else if (i_paddr == REG_DIV) begin
        div_reg_q <= i_pwdata[7:0];
      end
    end
  end

  // sticky events: a set in the clearing cycle survives
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      ist_q <= '0;
      o_irq <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~((wr && i_paddr == REG_ICLR) ? i_pwdata[IRQ_W-1:0] : '0)) | ev;
      o_irq <= |(ist_q & ien_q);
    end
  end

  // ---------------------------------------------------------------
  // dynamic config port and status outputs
  // ---------------------------------------------------------------
  // only open once the user design runs
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_dcp <= '0;
    end else begin
      o_dcp.rdy <= i_dcp.en && user_en_q;
      if (i_dcp.en && user_en_q) begin
        o_dcp.rdata <= dcp_mem[DW'(i_dcp.addr)];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_dcp.en && i_dcp.we && user_en_q) begin
      dcp_mem[DW'(i_dcp.addr)] <= i_dcp.wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      {o_user_en, o_done, o_error} <= '0;
    end else begin
      o_user_en <= user_en_q;
      o_done <= done_q;
      o_error <= err_q;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  sequence s_dcp_req;
    i_dcp.en && user_en_q;
  endsequence
  sequence s_dcp_ack;
    o_dcp.rdy;
  endsequence

  AST_PROG_RESTART: assert property (!prog_s |=> st_q == ST_HOLD && !user_en_q)
    else $error("program request did not restart");
  AST_USER_AFTER_CHECK: assert property ($rose(user_en_q) |-> $past(st_q) == ST_CHECK)
    else $error("user logic released without checked load");
  AST_POWERUP_OFF: assert property ($past(!i_nrst) |-> !o_user_en)
    else $error("user logic active right after reset");
  AST_WIDTH_LEGAL: assert property (st_q == ST_DETECT && rise |=> (mode_q == MD_PAR_FLASH)
    ? (wc_q inside {W8, W16}) : (wc_q inside {W1, W2, W4}))
    else $error("illegal detected width");
  AST_EXT_CLK: assert property (active && ext_sel_q && ext_s != ext_prev_q
    |=> cfg_clk_q != $past(cfg_clk_q))
    else $error("external clock edge not followed");
  AST_FALLBACK: assert property (fail_now && alt_q && !fb_q && prog_s && !reboot_p
    |=> st_q == ST_CLEAR && fb_q && base_q == 24'h000000)
    else $error("no fallback to original image");
  AST_SIZE: assert property (st_q == ST_HEAD && word_v_q && size_bad && prog_s && !reboot_p
    |=> st_q != ST_DATA)
    else $error("out of range image accepted");
  AST_PART_KEEP: assert property (part_q && st_q == ST_DATA |-> user_en_q)
    else $error("partial load stopped user logic");
  AST_DCP_RDY: assert property (s_dcp_req ##1 !i_dcp.en |-> s_dcp_ack ##1 !o_dcp.rdy)
    else $error("dynamic port answer not one cycle");
  AST_SLAVE_WORD: assert property (!master && wc_q == W32 && take && st_q != ST_CLEAR
    |=> word_v_q && word_q == $past(sd_s))
    else $error("slave word not taken");
  AST_FLASH_SEL: assert property (active |=> !o_flash.cs_n)
    else $error("flash not selected while loading");

endmodule : cfg_loader
`default_nettype wire

// ===== verification/flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------
// serial flash, one nibble per address
// -------------------------------
module flash_model
  import cfg_loader_pkg::*;
(
  input wire flash_out_t i_flash, // loader side
  output logic [15:0] o_data // data lanes
);
  logic [3:0] mem [0:1023];
  logic [15:0] last_q = 16'h0000;
  // deselected lanes show the inverse of the last value, never a held copy
  always_comb o_data = i_flash.cs_n ? ~last_q : {12'hFFF, mem[i_flash.addr[9:0]]};
  always @(posedge i_flash.clk) last_q <= o_data;
  task automatic put(input int a, input logic [31:0] w);
    for (int i = 0; i < 8; i++) mem[a + i] = w[31 - 4 * i -: 4];
  endtask : put
endmodule : flash_model
`default_nettype wire

// ===== verification/fpga_bitstream_config_loader_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fpga_bitstream_config_loader_bench
  import cfg_loader_pkg::*;
;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, prog_n = 1;
  logic irq, user_en, done, err, e, ext_clk = 0, slv_valid = 0;
  logic [31:0] slv_data = 0;
  logic [2:0] mode = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, w, seed = 32'd70919, pl [0:7];
  logic [255:0] fkey = 0, bkey = 0;
  logic [15:0] fdata;
  flash_out_t fo;
  dcp_req_t dcp = '0;
  dcp_rsp_t dr;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  // -------------------------------
  // design, flash and clock
  // -------------------------------
  cfg_loader #(.CFG_WORDS(64), .IMG_MIN_BITS(32), .IMG_MAX_BITS(4096)) cfg_loader_i (
    .i_clk_sys(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_prog_n(prog_n), .i_mode(mode), .i_ext_cfgclk(ext_clk),
    .i_flash_data(fdata), .o_flash(fo), .i_slv_valid(slv_valid), .i_slv_data(slv_data),
    .i_bbram_key(bkey), .i_fuse_key(fkey), .i_dcp(dcp), .o_dcp(dr), .o_user_en(user_en),
    .o_done(done), .o_error(err), .o_irq(irq));
  flash_model flash_model_i (.i_flash(fo), .o_data(fdata));
  initial forever #25 clk = ~clk;
  // external config clock, half period of four system cycles
  always @(posedge clk) if (cyc % 4 == 0) ext_clk <= ~ext_clk;
  // watchdog, a full run needs far fewer cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata; e = pslverr; psel <= 0; penable <= 0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(0, a, 0);
    chk($sformatf("reg %h", a), x, r & m);
  endtask : rd
  task automatic wait_done();
    while (done === 1'b1) @(posedge clk);
    while (done !== 1'b1) @(posedge clk);
  endtask : wait_done
  task automatic readback(input int b, input int n);
    for (int i = 0; i < n; i++) begin
      apb(1, REG_RBA, b + i);
      rd(REG_RBD, '1, pl[i]);
    end
  endtask : readback
  // image at nibble base b: detect, sync, header, payload, checksum
  task automatic img(input int b, input int n, input bit enc, input bit bad);
    logic [31:0] c, ks;
    c = 0; ks = 0;
    for (int i = 0; i < 8; i++) ks ^= fkey[32 * i +: 32];
    if (ks == 0) ks = 1;
    flash_model_i.mem[b] = 4'hF;
    flash_model_i.put(b + 1, SYNC_WORD);
    flash_model_i.put(b + 9, {enc, 1'b0, 30'(n)});
    for (int i = 0; i < n; i++) begin
      pl[i] = rnd();
      flash_model_i.put(b + 17 + 8 * i, enc ? pl[i] ^ ks : pl[i]);
      c = {c[30:0], c[31]} ^ pl[i];
      ks = {ks[30:0], 1'b0} ^ (ks[31] ? LFSR_POLY : 32'h0);
    end
    flash_model_i.put(b + 17 + 8 * n, c ^ 32'(bad));
  endtask : img
  // processor on the slave port: data settles before the strobe rises
  task automatic slv(input logic [31:0] d);
    slv_data <= d;
    repeat (3) @(posedge clk);
    slv_valid <= 1;
    repeat (3) @(posedge clk);
    slv_valid <= 0;
    repeat (3) @(posedge clk);
  endtask : slv
  task automatic slave_load(input int n);
    logic [31:0] c;
    c = 0;
    slv(SYNC_WORD);
    slv(32'(n));
    for (int i = 0; i < n; i++) begin
      pl[i] = rnd();
      c = {c[30:0], c[31]} ^ pl[i];
      slv(pl[i]);
    end
    slv(c);
  endtask : slave_load
  task automatic poll(input logic [3:0] s);
    r = 0;
    while (r[3:0] !== s) apb(0, REG_STAT, 0);
  endtask : poll
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // -------------------------------
  // main sequence
  // -------------------------------
  initial begin
    for (int i = 0; i < 8; i++) fkey[32 * i +: 32] <= rnd();
    for (int i = 0; i < 8; i++) bkey[32 * i +: 32] <= rnd();
    img(0, 4, 0, 0);
    repeat (3) @(posedge clk);
    nrst <= 1;
    rd(REG_DIV, '1, 32'(DIV_RST));
    rd(8'h40, '1, 0);
    chk("slverr", 1, e);
    wait_done();
    chk("user_en", 1, user_en);
    rd(REG_STAT, 32'hFFFF, 32'h230 | ST_DONE);
    readback(0, 4);
    rd(REG_ISTAT, 32'hF, 32'h1);
    chk("irq", 0, irq);
    apb(1, REG_IEN, 1);
    rd(REG_ISTAT, 32'h1, 32'h1);
    chk("irq", 1, irq);
    apb(1, REG_ICLR, 1);
    rd(REG_ISTAT, 32'h1, 0);
    chk("irq", 0, irq);
    w = rnd();
    dcp <= '{1'b1, 1'b1, 7'h05, w[15:0]};
    @(posedge clk) dcp <= '{1'b1, 1'b0, 7'h05, 16'h0};
    @(posedge clk) dcp.en <= 0;
    @(posedge clk) chk("dcp", {1'b1, w[15:0]}, dr);
    img(900, 2, 0, 0);
    apb(1, REG_IMG, 900);
    apb(1, REG_PBASE, 8);
    apb(1, REG_CTRL, 32'h2);
    poll(ST_DONE);
    chk("user_en", 1, user_en);
    rd(REG_STAT, 32'hC0FF, 32'h8037);
    readback(8, 2);
    img(400, 3, 1, 0);
    apb(1, REG_IMG, 400);
    apb(1, REG_CTRL, 32'hD);
    wait_done();
    rd(REG_STAT, 32'h40FF, 32'h4030 | ST_DONE);
    readback(0, 3);
    img(800, 3, 0, 1);
    apb(1, REG_IMG, 800);
    apb(1, REG_CTRL, 32'h1);
    wait_done();
    rd(REG_STAT, 32'hB0, 32'hB0);
    rd(REG_ISTAT, 32'h4, 32'h4);
    prog_n <= 0;
    repeat (5) @(posedge clk);
    chk("user_en", 0, user_en);
    prog_n <= 1;
    wait_done();
    rd(REG_ISTAT, 32'h8, 32'h8);
    mode <= 3'h4;
    prog_n <= 0;
    repeat (5) @(posedge clk);
    prog_n <= 1;
    poll(ST_SYNC);
    slave_load(3);
    while (done !== 1'b1) @(posedge clk);
    rd(REG_STAT, 32'hFFFF, 32'h2537);
    readback(0, 3);
    mode <= 3'h5;
    prog_n <= 0;
    repeat (5) @(posedge clk);
    prog_n <= 1;
    while (err !== 1'b1) @(posedge clk);
    chk("done", 0, done);
    final_report();
  end
endmodule : fpga_bitstream_config_loader_bench
`default_nettype wire
